/* hw/ascp_pkg.sv */
package ascp_pkg;
  typedef enum logic [1:0] {
    ASCP_RX_IDLE = 2'b01,
    ASCP_RX_BITS = 2'b10
  } ascp_rx_state_t;
endpackage

/* hw/ascp_regs.svh */
`ifndef ASCP_REGS_SVH
`define ASCP_REGS_SVH
`define ASCP_OFS_CTRL_ONE 5'h00
`define ASCP_OFS_CTRL_TWO 5'h04
`define ASCP_OFS_STATUS   5'h08
`define ASCP_OFS_DATA     5'h0C
`define ASCP_OFS_RATE     5'h10
// control one fields
`define ASCP_B_LOOP  7
`define ASCP_B_MEN   6
`define ASCP_B_INV   5
`define ASCP_B_LEN9  4
`define ASCP_B_WAKE  3
`define ASCP_B_IDLE_COUNT_ORIGIN  2
`define ASCP_B_PEN   1
`define ASCP_B_ODD   0
// control two fields
`define ASCP_B_TEIE  7
`define ASCP_B_TX_DONE_IRQ_EN  6
`define ASCP_B_RFIE  5
`define ASCP_B_IDLE_IRQ_EN  4
`define ASCP_B_TE    3
`define ASCP_B_RE    2
`define ASCP_B_RWU   1
`define ASCP_B_SBK   0
`define ASCP_RST_CTRL 8'h00
`define ASCP_RST_STAT 6'h03
`define ASCP_LEN_SHORT 4'hA
`define ASCP_LEN_LONG  4'hB
`define ASCP_RESP_OK  2'h0
`define ASCP_RESP_ERR 2'h2
`endif

/* hw/ascp_top.sv */
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ascp_regs.svh"
module ascp_top #(
  parameter int RATE_W   = 16,
  parameter int RATE_RST = 1085
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        port_dir_bit_five,
  input  wire logic        port_dir_bit_four,
  input  wire logic        port_out_five,
  input  wire logic        port_out_four,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  output logic             rx_pin_o,
  output logic             rx_pin_oe,
  input  wire logic        rx_pin_i,
  output logic             tx_irq,
  output logic             rx_irq
);
  initial begin
    if (RATE_W < 4 || RATE_W > 16 || RATE_RST < 4 || RATE_RST >= (1 << RATE_W))
      $error("ascp_top: rate parameters out of range");
  end

  logic [7:0]        ctrl_one_reg;
  logic [7:0]        ctrl_two_reg;
  logic [RATE_W-1:0] rate_reg;
  logic [8:0]        tx_data_reg;
  logic [8:0]        rx_data_reg;
  logic              tx_empty_flag;
  logic              tx_done_flag;
  logic              rx_full_flag;
  logic              idle_flag;
  logic              parity_err_reg;
  logic              frame_err_reg;
  logic [4:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [1:0]        w_strb_reg;
  logic              aw_have;
  logic              w_have;

  wire module_enable      = ctrl_one_reg[`ASCP_B_MEN];
  wire loopback_sel       = ctrl_one_reg[`ASCP_B_LOOP];
  wire tx_invert          = ctrl_one_reg[`ASCP_B_INV];
  wire len_nine           = ctrl_one_reg[`ASCP_B_LEN9];
  wire wake_addr          = ctrl_one_reg[`ASCP_B_WAKE];
  wire idle_count_origin  = ctrl_one_reg[`ASCP_B_IDLE_COUNT_ORIGIN];
  wire parity_enable      = ctrl_one_reg[`ASCP_B_PEN];
  wire parity_odd_sel     = ctrl_one_reg[`ASCP_B_ODD];
  wire transmitter_enable = ctrl_two_reg[`ASCP_B_TE];
  wire receiver_enable    = ctrl_two_reg[`ASCP_B_RE];
  wire rx_standby         = ctrl_two_reg[`ASCP_B_RWU];
  wire send_break         = ctrl_two_reg[`ASCP_B_SBK];
  wire [3:0] frame_len    = len_nine ? `ASCP_LEN_LONG : `ASCP_LEN_SHORT;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  wire wr_do = aw_have && w_have && !s_axi_bvalid;
  wire rd_do = s_axi_arvalid && s_axi_arready;
  wire wr_c1 = wr_do && aw_addr_reg == `ASCP_OFS_CTRL_ONE && w_strb_reg[0];
  wire wr_c2 = wr_do && aw_addr_reg == `ASCP_OFS_CTRL_TWO && w_strb_reg[0];
  wire wr_dt = wr_do && aw_addr_reg == `ASCP_OFS_DATA;
  wire wr_rt = wr_do && aw_addr_reg == `ASCP_OFS_RATE;
  wire rd_dt = rd_do && s_axi_araddr == `ASCP_OFS_DATA;
  wire wr_ok = aw_addr_reg <= `ASCP_OFS_RATE && aw_addr_reg[1:0] == 2'h0;
  wire rd_ok = s_axi_araddr <= `ASCP_OFS_RATE && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASCP_RESP_OK;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr_reg   <= 5'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb[1:0];
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `ASCP_RESP_OK : `ASCP_RESP_ERR;
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ASCP_RESP_OK;
    end else if (rd_do) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= rd_ok ? `ASCP_RESP_OK : `ASCP_RESP_ERR;
      if (s_axi_araddr == `ASCP_OFS_CTRL_ONE)
        s_axi_rdata <= {24'h000000, ctrl_one_reg};
      else if (s_axi_araddr == `ASCP_OFS_CTRL_TWO)
        s_axi_rdata <= {24'h000000, ctrl_two_reg};
      else if (s_axi_araddr == `ASCP_OFS_STATUS)
        s_axi_rdata <= {26'h0000000, frame_err_reg, parity_err_reg, idle_flag,
                        rx_full_flag, tx_done_flag, tx_empty_flag};
      else if (s_axi_araddr == `ASCP_OFS_DATA)
        s_axi_rdata <= {23'h000000, rx_data_reg};
      else if (s_axi_araddr == `ASCP_OFS_RATE)
        s_axi_rdata <= {{(32-RATE_W){1'b0}}, rate_reg};
      else
        s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic rx_wake;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_reg <= `ASCP_RST_CTRL;
      ctrl_two_reg <= `ASCP_RST_CTRL;
    end else begin
      if (wr_c1)
        ctrl_one_reg <= w_data_reg[7:0];
      if (wr_c2) begin
        ctrl_two_reg <= w_data_reg[7:0];
        if (!module_enable) begin
          ctrl_two_reg[`ASCP_B_TE] <= ctrl_two_reg[`ASCP_B_TE];
          ctrl_two_reg[`ASCP_B_RE] <= ctrl_two_reg[`ASCP_B_RE];
        end
      end else if (rx_wake) begin
        ctrl_two_reg[`ASCP_B_RWU] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_reg    <= RATE_W'(RATE_RST);
      tx_data_reg <= 9'h000;
    end else begin
      if (wr_rt)
        rate_reg <= w_data_reg[RATE_W-1:0];
      if (wr_dt)
        tx_data_reg <= w_data_reg[8:0];
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [RATE_W-1:0] baud_cnt;
  logic              baud_tick;
  logic [10:0]       tx_sh;
  logic [3:0]        tx_left;
  logic              te_prev;
  logic              pre_pend;
  logic              gap_pend;
  logic              last_break;

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_enable) begin
      baud_cnt  <= '0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= baud_cnt == rate_reg;
      baud_cnt  <= baud_cnt == rate_reg ? '0 : baud_cnt + 1'b1;
    end
  end

  wire       tx_busy   = tx_left != 4'h0;
  wire       tx_line   = tx_busy ? tx_sh[0] : 1'b1;
  wire       tx_load   = baud_tick && (tx_left == 4'h1 || !tx_busy) && transmitter_enable;
  wire       par_bit   = (len_nine ? ^tx_data_reg[7:0] : ^tx_data_reg[6:0]) ^ parity_odd_sel;
  wire [8:0] tx_char   = len_nine ?
                         {parity_enable ? par_bit : tx_data_reg[8], tx_data_reg[7:0]} :
                         {1'b1, parity_enable ? par_bit : tx_data_reg[7], tx_data_reg[6:0]};
  wire       pick_pre  = pre_pend;
  wire       pick_brk  = !pre_pend && send_break;
  // the load that ends a break takes the gap, or waiting data would follow with no one
  wire       pick_gap  = !pre_pend && !send_break && (gap_pend || last_break);
  wire       pick_dat  = !pre_pend && !send_break && !gap_pend && !last_break && !tx_empty_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh      <= 11'h7FF;
      tx_left    <= 4'h0;
      te_prev    <= 1'b0;
      pre_pend   <= 1'b0;
      gap_pend   <= 1'b0;
      last_break <= 1'b0;
    end else begin
      te_prev <= transmitter_enable;
      if (transmitter_enable && !te_prev)
        pre_pend <= 1'b1;
      if (!module_enable) begin
        tx_left  <= 4'h0;
        pre_pend <= 1'b0;
        gap_pend <= 1'b0;
      end else if (tx_load) begin
        if (pick_pre) begin
          tx_sh    <= 11'h7FF;
          tx_left  <= frame_len;
          pre_pend <= 1'b0;
        end else if (pick_brk) begin
          tx_sh      <= 11'h000;
          tx_left    <= frame_len;
          last_break <= 1'b1;
        end else if (pick_gap) begin
          tx_sh    <= 11'h7FF;
          tx_left  <= 4'h1;
          gap_pend <= 1'b0;
        end else if (pick_dat) begin
          tx_sh   <= {1'b1, tx_char, 1'b0};
          tx_left <= frame_len;
        end else begin
          tx_left <= 4'h0;
        end
        if (!pick_brk && last_break) begin
          last_break <= 1'b0;
        end
      end else if (baud_tick && tx_busy) begin
        // frame runs out even when disabled
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
      end
      if (module_enable && !tx_load && last_break && !send_break && !tx_busy)
        gap_pend <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_enable)
      tx_empty_flag <= 1'b1;
    else if (tx_load && pick_dat)
      tx_empty_flag <= 1'b1;
    else if (wr_dt)
      tx_empty_flag <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_enable)
      tx_done_flag <= 1'b1;
    else
      tx_done_flag <= tx_empty_flag && !wr_dt && !tx_busy && !pre_pend && !gap_pend &&
                      !(transmitter_enable && send_break) && !tx_load;
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_o  <= 1'b0;
      tx_pin_oe <= 1'b0;
      rx_pin_o  <= 1'b0;
      rx_pin_oe <= 1'b0;
    end else begin
      tx_pin_oe <= module_enable | port_dir_bit_five;
      tx_pin_o  <= module_enable ? tx_line ^ tx_invert : port_out_five;
      rx_pin_oe <= !module_enable && port_dir_bit_four;
      rx_pin_o  <= port_out_four;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  ascp_pkg::ascp_rx_state_t rx_state;
  logic [RATE_W-1:0] rx_cnt;
  logic [3:0]        rx_nbit;
  logic [10:0]       rx_sh;
  logic [3:0]        ones_cnt;
  logic              idle_armed;
  logic              rx_got;
  logic              rx_src_msb_q;

  wire       rx_on   = module_enable && receiver_enable;
  wire       rx_src  = loopback_sel ? tx_line : rx_pin_i;
  wire       rx_smp  = rx_cnt == '0;
  wire [8:0] rx_char = len_nine ? rx_sh[9:1] : {1'b0, rx_sh[8:1]};
  wire       rx_msb  = len_nine ? rx_sh[9] : rx_sh[8];
  wire       rx_stop = len_nine ? rx_sh[10] : rx_sh[9];
  wire       rx_par  = (len_nine ? ^rx_sh[9:1] : ^rx_sh[8:1]) ^ parity_odd_sel;
  // whole frame sits in the shifter the cycle after its stop sample
  wire       rx_end  = rx_got;
  wire       idle_ev = rx_smp && rx_src && ones_cnt == frame_len - 4'h1;
  assign     rx_wake = rx_standby && (wake_addr ? rx_end && rx_msb : idle_ev);

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_on) begin
      rx_state <= ascp_pkg::ASCP_RX_IDLE;
      rx_cnt   <= '0;
      rx_nbit  <= 4'h0;
      rx_sh    <= 11'h7FF;
      ones_cnt <= 4'h0;
    end else begin
      rx_cnt <= rx_smp ? rate_reg : rx_cnt - 1'b1;
      case (rx_state)
        ascp_pkg::ASCP_RX_IDLE: begin
          if (!rx_src) begin
            rx_state <= ascp_pkg::ASCP_RX_BITS;
            rx_cnt   <= rate_reg >> 1;
            rx_nbit  <= 4'h0;
          end else if (rx_smp && ones_cnt != frame_len) begin
            ones_cnt <= ones_cnt + 4'h1;
          end
        end
        ascp_pkg::ASCP_RX_BITS: begin
          if (rx_smp) begin
            rx_sh[rx_nbit] <= rx_src;
            rx_nbit        <= rx_nbit + 4'h1;
            if (rx_nbit == 4'h0 || !rx_src || idle_count_origin)
              ones_cnt <= 4'h0;
            else if (ones_cnt != frame_len)
              ones_cnt <= ones_cnt + 4'h1;
            if (rx_nbit == 4'h0 && rx_src)
              rx_state <= ascp_pkg::ASCP_RX_IDLE;
            if (rx_nbit == frame_len - 4'h1)
              rx_state <= ascp_pkg::ASCP_RX_IDLE;
          end
        end
        default: rx_state <= ascp_pkg::ASCP_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    rx_got <= aresetn && rx_on && rx_state == ascp_pkg::ASCP_RX_BITS && rx_smp &&
              rx_nbit == frame_len - 4'h1 && (!rx_standby || wake_addr && rx_src_msb_q);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_src_msb_q <= 1'b0;
    else if (rx_smp && rx_nbit == frame_len - 4'h2)
      rx_src_msb_q <= rx_src;
  end

  // flags: a set in the same cycle as the data read wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_flag   <= 1'b0;
      idle_flag      <= 1'b0;
      parity_err_reg <= 1'b0;
      frame_err_reg  <= 1'b0;
      idle_armed     <= 1'b0;
      rx_data_reg    <= 9'h000;
    end else if (rx_got) begin
      rx_full_flag   <= 1'b1;
      idle_armed     <= 1'b1;
      rx_data_reg    <= rx_char;
      parity_err_reg <= parity_enable && rx_par;
      frame_err_reg  <= !rx_stop;
    end else if (idle_ev && rx_on && !rx_standby && idle_armed) begin
      idle_flag  <= 1'b1;
      idle_armed <= 1'b0;
    end else if (rd_dt) begin
      rx_full_flag   <= 1'b0;
      idle_flag      <= 1'b0;
      parity_err_reg <= 1'b0;
      frame_err_reg  <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= module_enable &&
                (ctrl_two_reg[`ASCP_B_TEIE] && tx_empty_flag ||
                 ctrl_two_reg[`ASCP_B_TX_DONE_IRQ_EN] && tx_done_flag);
      rx_irq <= !rx_standby &&
                (ctrl_two_reg[`ASCP_B_RFIE] && rx_full_flag ||
                 ctrl_two_reg[`ASCP_B_IDLE_IRQ_EN] && idle_flag);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rise_te;
    !te_prev && transmitter_enable && module_enable;
  endsequence
  // a queued preamble waits out at most one frame in progress: eleven ticks
  logic [3:0] pre_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pre_pend || !transmitter_enable || !module_enable)
      pre_ticks <= 4'h0;
    else if (baud_tick && pre_ticks != 4'hF)
      pre_ticks <= pre_ticks + 4'h1;
  end
  sequence s_pre_late;
    pre_ticks > 4'hB;
  endsequence
  AST_PIN_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(module_enable) |=> tx_pin_oe) else $error("tx pin not driven");
  AST_PIN_IN: assert property (@(posedge aclk) disable iff (!aresetn)
    module_enable && $past(module_enable) |-> !rx_pin_oe) else $error("rx pin driven");
  AST_INV: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(module_enable) |-> tx_pin_o == ($past(tx_line) ^ $past(tx_invert)))
    else $error("tx level wrong");
  AST_DISABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !module_enable |=> tx_empty_flag && tx_done_flag && !tx_irq) else $error("disable");
  AST_PREAMBLE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rise_te |=> pre_pend) else $error("no preamble queued");
  AST_BRK_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && pick_brk && module_enable |=> tx_sh == 11'h000 && tx_left == frame_len)
    else $error("break frame wrong");
  AST_EMPTY: assert property (@(posedge aclk) disable iff (!aresetn)
    module_enable && tx_load && pick_dat |=> tx_empty_flag) else $error("empty not set");
  AST_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_busy && module_enable |=> !tx_done_flag) else $error("done while busy");
  AST_PRE_SENT: assert property (@(posedge aclk) disable iff (!aresetn)
    not s_pre_late) else $error("preamble waited too long");
  AST_RXIRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_standby |=> !rx_irq) else $error("rx irq in standby");
  AST_RST: assert property (@(posedge aclk)
    !aresetn |=> ctrl_one_reg == 8'h00 && ctrl_two_reg == 8'h00) else $error("reset");
endmodule

/* sim/ascp_remote.sv */
`timescale 1ns/1ps
// ----------------------------------------
// remote transmitter on the receive pin
// ----------------------------------------
module ascp_remote #(
  parameter int BIT_CLKS = 8
) (
  input  wire logic       aclk,
  input  wire logic       send_req,
  input  wire logic [7:0] send_data,
  output logic            line_o
);
  logic [9:0] f;
  // line idles at the mark level between frames; one process owns it
  initial begin
    line_o = 1'b1;
    forever begin
      @(posedge aclk);
      if (send_req) begin
        // one start bit, eight data bits lsb first, one stop bit
        f = {1'b1, send_data, 1'b0};
        for (int i = 0; i < 10; i++) begin
          line_o <= f[i];
          repeat (BIT_CLKS) @(posedge aclk);
        end
      end
    end
  end
endmodule

/* sim/async_serial_control_pins_tb.sv */
`timescale 1ns/1ps
module async_serial_control_pins_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, p, rsend;
  logic [1:0]  bresp, rresp;
  logic        dir5, dir4, out5, out4, tx_o, tx_oe, rx_o, rx_oe, rx_line, tx_irq, rx_irq;
  logic [33:0] exp_q[$];
  logic [9:0]  f;
  logic [7:0]  d;
  int          fail_count, comparisons, n;

  ascp_top #(.RATE_RST(7)) ascp_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_dir_bit_five(dir5), .port_dir_bit_four(dir4), .port_out_five(out5),
    .port_out_four(out4), .tx_pin_o(tx_o), .tx_pin_oe(tx_oe), .rx_pin_o(rx_o),
    .rx_pin_oe(rx_oe), .rx_pin_i(rx_line), .tx_irq(tx_irq), .rx_irq(rx_irq));
  ascp_remote ascp_remote_inst (.aclk(aclk), .send_req(rsend), .send_data(d),
    .line_o(rx_line));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read results are matched against the oldest note
  always @(posedge aclk) if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    chk(bresp, (a <= 5'h10 && a[1:0] == 2'h0) ? 2'h0 : 2'h2);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    exp_q.push_back(e);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  // bounded wait: 0 tx low, 1 rx request, 2 tx high; a hang fails a later compare
  task automatic wait_sig(input int which);
    n = 0;
    while (n < 400 && (which == 1 ? rx_irq !== 1'b1 : tx_o !== (which == 2))) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #80000;
    fail_count++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dir5, dir4, out5, out4, rsend} = 11'h0;
    {awaddr, araddr, wdata} = 42'h0;
    void'($urandom(32'hFE48));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h00, 34'h0);
    rd(5'h04, 34'h0);
    rd(5'h08, 34'h3);
    rd(5'h14, {2'h2, 32'h0});
    wr(5'h14, 32'h0);
    // enables are refused while the module is off
    wr(5'h04, 32'hC);
    rd(5'h04, 34'h0);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) wr(5'h00, 32'h40);
      repeat (4) begin
        @(posedge aclk);
        {dir5, dir4, out5, out4} <= 4'($urandom);
        repeat (3) @(posedge aclk);
        chk(tx_oe, m ? 1'b1 : dir5);
        chk(tx_o, m ? 1'b1 : out5);
        chk(rx_oe, m ? 1'b0 : dir4);
        chk(rx_o, out4);
      end
    end
    wr(5'h00, 32'h60);
    repeat (3) @(posedge aclk);
    chk(tx_o, 1'b0);
    wr(5'h04, 32'h80);
    repeat (3) @(posedge aclk);
    chk(tx_irq, 1'b1);
    wr(5'h00, 32'h0);
    repeat (3) @(posedge aclk);
    chk(tx_irq, 1'b0);
    rd(5'h08, 34'h3);
    wr(5'h00, 32'h40);
    wr(5'h04, 32'h08);
    // plain, even and odd parity frames
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      wr(5'h00, (k == 0) ? 32'h40 : 32'h41 + 32'(k));
      wr(5'h0C, {24'h0, d});
      wait_sig(0);
      if (k == 0) chk(n > 60, 1'b1);
      repeat (4) @(posedge aclk);
      p = (k == 0) ? d[7] : (^d[6:0]) ^ (k == 2);
      f = {1'b1, p, d[6:0], 1'b0};
      for (int i = 0; i < 10; i++) begin
        chk(tx_o, f[i]);
        repeat (8) @(posedge aclk);
      end
    end
    wr(5'h04, 32'h09);
    wait_sig(0);
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 20; i++) begin
      chk(tx_o, 1'b0);
      repeat (8) @(posedge aclk);
    end
    wr(5'h04, 32'h2C);
    // data waits behind the last break: exactly one bit time of ones between them
    wr(5'h0C, 32'h55);
    wait_sig(2);
    wait_sig(0);
    chk(34'(n), 34'h8);
    d = 8'($urandom);
    rsend <= 1'b1;
    @(posedge aclk);
    rsend <= 1'b0;
    wait_sig(1);
    chk(rx_irq, 1'b1);
    rd(5'h0C, {26'h0, d});
    repeat (3) @(posedge aclk);
    chk(rx_irq, 1'b0);
    // loopback: the data can only arrive through the internal path
    wr(5'h00, 32'hC0);
    d = 8'($urandom);
    wr(5'h0C, {24'h0, d});
    wait_sig(1);
    rd(5'h0C, {26'h0, d});
    repeat (4) @(posedge aclk);
    finish_test();
  end
endmodule
